// file: design/mfr_pkg.sv
// package of constants and types for the motor fault reset manager
package mfr_pkg;
  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SUCCESS_RUN_S = 60; // one minute of clean running
  localparam int unsigned CYCLES_PER_S = CLK_HZ;
  localparam int unsigned SUCCESS_RUN_CYCLES_S = SUCCESS_RUN_S;
  // ==========================================================================
  // fault vector layout (one bit per fault category)
  localparam int unsigned NUM_FAULTS = 8;
  localparam int unsigned F_DIAG = 0;
  localparam int unsigned F_WIRING = 1;
  localparam int unsigned F_INTERNAL = 2;
  localparam int unsigned F_MOTOR_TEMP = 3;
  localparam int unsigned F_THERMAL = 4;
  localparam int unsigned F_CURRENT = 5;
  localparam int unsigned F_VOLT_POWER = 6;
  localparam int unsigned F_COMM_LOSS = 7;
  // ==========================================================================
  // auto-reset groups and settings
  localparam int unsigned NUM_GROUPS = 3;
  localparam int unsigned TIMEOUT_W = 16; // up to 65,535 s
  localparam logic [2:0] ATTEMPTS_MANUAL = 3'h0;
  localparam logic [2:0] ATTEMPTS_UNLIMITED = 3'h5;
  localparam logic [2:0] ATTEMPT_CNT_RESET = 3'h0;
  localparam logic [TIMEOUT_W-1:0] TIMEOUT_RESET = 16'h0000;
  localparam logic [1:0] GROUP_NONE = 2'h3;
  // control channel encodings
  typedef enum logic [1:0] {
    MFR_CH_TERMINAL = 2'b00,
    MFR_CH_PANEL = 2'b01,
    MFR_CH_NETWORK = 2'b10
  } mfr_channel_t;
  // reset mode
  typedef enum logic {
    MFR_MODE_MANUAL = 1'b0,
    MFR_MODE_AUTO = 1'b1
  } mfr_mode_t;
endpackage

// file: design/mfr_group_timer.sv
// one auto-reset group: timeout countdown, attempt counter, success timer
`timescale 1ns/10ps
module mfr_group_timer #(
  parameter int unsigned CYCLES_PER_S = mfr_pkg::CYCLES_PER_S,
  parameter int unsigned SUCCESS_S = mfr_pkg::SUCCESS_RUN_CYCLES_S
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic clear_cfg_in,
  input wire logic cfg_we_in,
  input wire logic [2:0] cfg_attempts_in,
  input wire logic [mfr_pkg::TIMEOUT_W-1:0] cfg_timeout_in,
  input wire logic auto_en_in,
  input wire logic fault_in,
  input wire logic motor_running_in,
  output logic auto_reset_out,
  output logic exhausted_out,
  output logic [2:0] attempts_out,
  output logic [mfr_pkg::TIMEOUT_W-1:0] timeout_out,
  output logic [2:0] attempt_count_out
);
  typedef struct packed {
    logic [2:0] attempts;
    logic [mfr_pkg::TIMEOUT_W-1:0] timeout;
    logic [2:0] count;
    logic [mfr_pkg::TIMEOUT_W-1:0] remaining_s;
    logic [31:0] prescale;
    logic [31:0] run_s;
    logic counting;
    logic pulse;
  } mfr_grp_state_t;

  mfr_grp_state_t state;
  mfr_grp_state_t next_state;
  logic sec_tick;
  logic finite_used;

  // ==========================================================================
  // next state
  always_comb begin
    next_state = state;
    next_state.pulse = 1'b0;
    sec_tick = (state.prescale == 32'(CYCLES_PER_S - 1));
    next_state.prescale = sec_tick ? 32'h0 : state.prescale + 32'h1;
    finite_used = (state.attempts != mfr_pkg::ATTEMPTS_UNLIMITED) &&
                  (state.count >= state.attempts);
    if (cfg_we_in) begin
      next_state.attempts = (cfg_attempts_in > mfr_pkg::ATTEMPTS_UNLIMITED) ?
                            mfr_pkg::ATTEMPTS_UNLIMITED : cfg_attempts_in;
      next_state.timeout = cfg_timeout_in;
    end
    // success: one minute of running with no group fault
    if (fault_in || !motor_running_in) begin
      next_state.run_s = 32'h0;
    end else if (sec_tick && state.run_s < 32'(SUCCESS_S)) begin
      next_state.run_s = state.run_s + 32'h1;
    end else if (state.run_s == 32'(SUCCESS_S) && state.count != 3'h0) begin
      next_state.count = mfr_pkg::ATTEMPT_CNT_RESET;
    end
    // countdown starts when a fault appears; reset only once it ends
    if (!fault_in) begin
      next_state.counting = 1'b0;
    end else if (!state.counting) begin
      next_state.counting = 1'b1;
      next_state.remaining_s = state.timeout;
      next_state.prescale = 32'h0;
    end else if (state.remaining_s != 16'h0000) begin
      if (sec_tick) next_state.remaining_s = state.remaining_s - 16'h0001;
    end else if (auto_en_in && state.attempts != mfr_pkg::ATTEMPTS_MANUAL &&
                 state.timeout != 16'h0000 && !finite_used) begin
      next_state.pulse = 1'b1;
      next_state.counting = 1'b0; // re-arm a fresh wait for a retry
      // unlimited retries count too, saturating so the count never wraps
      if (state.count != 3'h7) begin
        next_state.count = state.count + 3'h1;
      end
    end
    // power-cycle or fall-back zeroing wins over a write
    if (clear_cfg_in) begin
      next_state.attempts = mfr_pkg::ATTEMPTS_MANUAL;
      next_state.timeout = mfr_pkg::TIMEOUT_RESET;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state <= '0; // power-up clears all settings
    end else begin
      state <= next_state;
    end
  end

  assign auto_reset_out = state.pulse;
  assign exhausted_out = fault_in && state.counting && state.remaining_s == 16'h0000 &&
                         state.attempts != mfr_pkg::ATTEMPTS_MANUAL &&
                         state.attempts != mfr_pkg::ATTEMPTS_UNLIMITED &&
                         state.count >= state.attempts;
  assign attempts_out = state.attempts;
  assign timeout_out = state.timeout;
  assign attempt_count_out = state.count;
endmodule // mfr_group_timer

// file: design/mfr_fault_reset_manager.sv
// top of the motor fault reset manager: source qualification and fault clears
// Structure
// five source pins pass two flops, then a rising-edge detect
// one edge per press, so a held button clears only once
// a clear mask per fault category picks the legal sources
// a fresh detection wins over a clear in the same cycle
// three group engines run timeouts, attempts and clean runs
// an exhausted group drops the block back to manual mode
// a motor restart after fall-back zeroes every group setting
// the thermal capacity level itself lives outside this block
// limitation: a press shorter than one clock may be missed
`timescale 1ns/10ps
module mfr_fault_reset_manager #(
  parameter int unsigned CYCLES_PER_S = mfr_pkg::CYCLES_PER_S
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // reset sources (pins pass a synchroniser)
  input wire logic reset_input_in,
  input wire logic reset_button_source_in,
  input wire logic operator_panel_reset_in,
  input wire logic network_reset_in,
  input wire logic power_cycle_source_in,
  // configuration
  input wire logic mode_auto_in,
  input wire logic mode_we_in,
  input wire logic [1:0] control_channel_in,
  input wire logic [mfr_pkg::NUM_GROUPS-1:0] group_cfg_we_in,
  input wire logic [2:0] group_attempts_in,
  input wire logic [mfr_pkg::TIMEOUT_W-1:0] group_timeout_in,
  // fault detection from protection functions
  input wire logic [mfr_pkg::NUM_FAULTS-1:0] fault_detect_in,
  input wire logic inverse_thermal_trip_in,
  input wire logic clear_thermal_cmd_in,
  input wire logic motor_running_in,
  // status
  output logic [mfr_pkg::NUM_FAULTS-1:0] fault_latched_out,
  output logic mode_auto_out,
  output logic clear_thermal_capacity_out,
  output logic [3*mfr_pkg::NUM_GROUPS-1:0] attempt_count_out,
  output logic [3*mfr_pkg::NUM_GROUPS-1:0] attempts_setting_out,
  output logic [mfr_pkg::TIMEOUT_W*mfr_pkg::NUM_GROUPS-1:0] timeout_setting_out
);
  // ==========================================================================
  // sizes
  localparam int unsigned NF = mfr_pkg::NUM_FAULTS;
  localparam int unsigned NG = mfr_pkg::NUM_GROUPS;

  // ==========================================================================
  // registered state
  // five source bits: input, button, panel, network, power cycle
  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync_prev;
    logic [NF-1:0] latched;
    logic mode_auto;
    logic fell_back;
    logic motor_prev;
    logic thermal_clear;
    logic inverse_seen;
  } mfr_top_state_t;

  // ==========================================================================
  // state copies and combinational decode
  mfr_top_state_t state;
  mfr_top_state_t next_state;
  logic [4:0] rise;
  logic local_reset;
  logic net_reset;
  logic pc_reset;
  logic [NF-1:0] clear_mask;
  logic [NG-1:0] auto_pulse;
  logic [NG-1:0] exhausted;
  logic [NG-1:0] grp_fault;
  logic clear_cfg;
  logic restart;

  // ==========================================================================
  // fault grouping
  // fault to auto-reset group; GROUP_NONE for faults never auto-reset
  function automatic logic [1:0] group_of(input int unsigned f);
    case (f)
      mfr_pkg::F_MOTOR_TEMP, mfr_pkg::F_THERMAL: group_of = 2'h0;
      mfr_pkg::F_CURRENT, mfr_pkg::F_VOLT_POWER: group_of = 2'h1;
      mfr_pkg::F_COMM_LOSS: group_of = 2'h2;
      default: group_of = mfr_pkg::GROUP_NONE;
    endcase
  endfunction

  // ==========================================================================
  // reset qualification
  always_comb begin
    rise = state.sync2 & ~state.sync_prev;
    // button on front face or panel counts alike
    local_reset = rise[0] | rise[1] | rise[2];
    pc_reset = rise[4];
    // network only in automatic mode with network channel
    net_reset = rise[3] && state.mode_auto &&
                control_channel_in == mfr_pkg::MFR_CH_NETWORK;
    // motor start edge, for the fall-back clear
    restart = motor_running_in && !state.motor_prev;
    // settings zero on power cycle or on restart after fall-back
    clear_cfg = pc_reset || (state.fell_back && restart);
    // group fault is any latched member of that group
    grp_fault = '0;
    clear_mask = '0;
    for (int f = 0; f < NF; f++) begin
      if (group_of(f) != mfr_pkg::GROUP_NONE) begin
        grp_fault[group_of(f)] = grp_fault[group_of(f)] | state.latched[f];
      end
      // internal faults: a power cycle is the only way out
      if (f == mfr_pkg::F_INTERNAL) begin
        clear_mask[f] = pc_reset;
      end else if (f == mfr_pkg::F_DIAG || f == mfr_pkg::F_WIRING) begin
        // network clears diagnostics only, never wiring
        clear_mask[f] = pc_reset || local_reset ||
                        (net_reset && f == mfr_pkg::F_DIAG);
      end else begin
        // protection faults survive a power cycle
        clear_mask[f] = local_reset || net_reset ||
                        (state.mode_auto && auto_pulse[group_of(f)]);
      end
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    next_state = state;
    // source pins enter the first synchroniser flop
    next_state.sync1 = {power_cycle_source_in, network_reset_in, operator_panel_reset_in,
                        reset_button_source_in, reset_input_in};
    next_state.sync2 = state.sync1;
    next_state.sync_prev = state.sync2;
    next_state.motor_prev = motor_running_in;
    // a new detection wins over a clear in the same cycle
    next_state.latched = (state.latched & ~clear_mask) | fault_detect_in;
    // mode write; an exhausted group in the same cycle still wins if the block is already in automatic mode
    if (mode_we_in) begin
      next_state.mode_auto = mode_auto_in;
      next_state.fell_back = 1'b0;
    end
    // fall back to manual once a group has run out of attempts
    if (state.mode_auto && |exhausted) begin
      next_state.mode_auto = mfr_pkg::MFR_MODE_MANUAL;
      next_state.fell_back = 1'b1;
    end
    // the restart consumes the fall-back flag
    if (state.fell_back && restart) next_state.fell_back = 1'b0;
    // one-cycle pulse to zero thermal capacity
    next_state.thermal_clear = clear_thermal_cmd_in && state.inverse_seen;
    // the command consumes the inverse flag
    if (clear_thermal_cmd_in && state.inverse_seen) next_state.inverse_seen = 1'b0;
    // set after clear, so a trip in the command cycle is not lost
    if (fault_detect_in[mfr_pkg::F_THERMAL] && inverse_thermal_trip_in) begin
      next_state.inverse_seen = 1'b1;
    end
  end

  // ==========================================================================
  // state register; manual mode after power-up
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // per-group auto-reset engines
  // one write bus for all groups; the strobe bit picks the group
  // each engine sees only its own group's fault
  for (genvar g = 0; g < NG; g++) begin : g_grp
    mfr_group_timer #(
      .CYCLES_PER_S(CYCLES_PER_S),
      .SUCCESS_S(mfr_pkg::SUCCESS_RUN_CYCLES_S)
    ) u_grp (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .clear_cfg_in(clear_cfg),
      .cfg_we_in(group_cfg_we_in[g]),
      .cfg_attempts_in(group_attempts_in),
      .cfg_timeout_in(group_timeout_in),
      .auto_en_in(state.mode_auto),
      .fault_in(grp_fault[g]),
      .motor_running_in(motor_running_in),
      .auto_reset_out(auto_pulse[g]),
      .exhausted_out(exhausted[g]),
      .attempts_out(attempts_setting_out[3*g +: 3]),
      .timeout_out(timeout_setting_out[mfr_pkg::TIMEOUT_W*g +: mfr_pkg::TIMEOUT_W]),
      .attempt_count_out(attempt_count_out[3*g +: 3])
    );
  end

  // ==========================================================================
  // outputs, all straight from flops
  assign fault_latched_out = state.latched;
  assign mode_auto_out = state.mode_auto;
  assign clear_thermal_capacity_out = state.thermal_clear;
endmodule // mfr_fault_reset_manager

// file: sim/mfr_fault_reset_manager_asserts.sv
// port checker of the motor fault reset manager
`timescale 1ns/10ps
module mfr_fault_reset_manager_asserts #(
  parameter int unsigned CYCLES_PER_S = 10
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic reset_input_in,
  input wire logic reset_button_source_in,
  input wire logic operator_panel_reset_in,
  input wire logic power_cycle_source_in,
  input wire logic clear_thermal_cmd_in,
  input wire logic motor_running_in,
  input wire logic [7:0] fault_detect_in,
  input wire logic [7:0] fault_latched_out,
  input wire logic mode_auto_out,
  input wire logic clear_thermal_capacity_out,
  input wire logic [8:0] attempt_count_out,
  input wire logic [8:0] attempts_setting_out,
  input wire logic [47:0] timeout_setting_out
);
  logic [3:0] loc_age;
  logic [3:0] pc_age;
  // ==========================================================================
  // age of the last local and power-cycle event, saturating so old ones expire
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      loc_age <= 4'hF;
      pc_age <= 4'hF;
    end else begin
      loc_age <= (reset_input_in | reset_button_source_in | operator_panel_reset_in) ? 4'h0 :
        loc_age + {3'h0, loc_age != 4'hF};
      pc_age <= power_cycle_source_in ? 4'h0 : pc_age + {3'h0, pc_age != 4'hF};
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================================
  // clearing sources
  a_internal_by_pc: assert property ($fell(fault_latched_out[2]) |-> pc_age < 4'h8)
    else $error("internal fault cleared without power cycle");
  a_protect_local: assert property (
    ((($past(fault_latched_out) & ~fault_latched_out) & 8'hF8) != 8'h00)
    && !mode_auto_out && !$past(mode_auto_out) |-> loc_age < 4'h8)
    else $error("protection fault cleared without local reset");
  a_diag_manual: assert property (
    ((($past(fault_latched_out) & ~fault_latched_out) & 8'h03) != 8'h00)
    && !mode_auto_out |-> (loc_age < 4'h8) || (pc_age < 4'h8))
    else $error("diagnostic fault cleared by network in manual");
  a_fault_sets: assert property (fault_detect_in != 8'h00 |=>
    (fault_latched_out & $past(fault_detect_in)) == $past(fault_detect_in))
    else $error("detected fault not latched");
  // ==========================================================================
  // settings, thermal command and fall-back
  a_thermal_pulse: assert property (clear_thermal_capacity_out |->
    $past(clear_thermal_cmd_in) ##1 !clear_thermal_capacity_out)
    else $error("thermal clear pulse wrong");
  a_pc_zeroes: assert property ($rose(power_cycle_source_in) |->
    ##[3:8] (attempts_setting_out == 9'h000) && (timeout_setting_out == 48'h0))
    else $error("power cycle left group settings");
  a_attempt_range: assert property (attempts_setting_out[2:0] <= 3'h5 &&
    attempts_setting_out[5:3] <= 3'h5 && attempts_setting_out[8:6] <= 3'h5)
    else $error("attempt setting above five");
  a_fallback_zero: assert property (
    $fell(mode_auto_out) ##[0:300] $rose(motor_running_in) |->
    ##[1:4] attempts_setting_out == 9'h000)
    else $error("restart after fall-back kept settings");
  a_count_limit: assert property (
    attempts_setting_out[2:0] inside {3'h1, 3'h2, 3'h3, 3'h4} |->
    attempt_count_out[2:0] <= attempts_setting_out[2:0])
    else $error("attempt count beyond limit");
  c_fallback: cover property ($fell(mode_auto_out));
  c_thermal: cover property (clear_thermal_capacity_out);
  c_internal: cover property ($fell(fault_latched_out[2]));
endmodule // mfr_fault_reset_manager_asserts

// file: sim/mfr_reset_source_model.sv
// reset sources outside the block: input pin, button, panel, network, power cycle
`timescale 1ns/10ps
module mfr_reset_source_model (
  input wire logic mclk_in,
  input wire logic go_in,
  input wire logic [2:0] sel_in,
  output logic [4:0] src_out
);
  logic [1:0] hold = 2'h0;
  initial src_out = 5'h00;
  // ==========================================================================
  // each press lasts three cycles, then the line rests low before the next one
  always @(posedge mclk_in) begin
    if (go_in) begin
      src_out <= 5'h01 << sel_in;
      hold <= 2'h2;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else begin
      src_out <= 5'h00;
    end
  end
endmodule // mfr_reset_source_model

// file: sim/mfr_fault_reset_manager_tb_top.sv
// self-checking bench of the motor fault reset manager
`timescale 1ns/10ps
module mfr_fault_reset_manager_tb_top;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic go = 1'b0;
  logic [2:0] sel = 3'h0;
  wire logic [4:0] src;
  logic mode_auto_in = 1'b0;
  logic mode_we_in = 1'b0;
  logic [1:0] control_channel_in = 2'h0;
  logic [2:0] group_cfg_we_in = 3'h0;
  logic [2:0] group_attempts_in = 3'h0;
  logic [15:0] group_timeout_in = 16'h0000;
  logic [7:0] fault_detect_in = 8'h00;
  logic inverse_thermal_trip_in = 1'b0;
  logic clear_thermal_cmd_in = 1'b0;
  logic motor_running_in = 1'b0;
  logic [7:0] fault_latched_out;
  logic mode_auto_out;
  logic clear_thermal_capacity_out;
  logic [8:0] attempt_count_out;
  logic [8:0] attempts_setting_out;
  logic [47:0] timeout_setting_out;
  logic [7:0] exp_lat = 8'h00;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int hits;
  // one second is ten cycles so the one-minute success run stays short
  mfr_fault_reset_manager #(.CYCLES_PER_S(10)) i_mfr_fault_reset_manager (.mclk_in, .rst_n_in,
    .reset_input_in(src[0]), .reset_button_source_in(src[1]), .operator_panel_reset_in(src[2]),
    .network_reset_in(src[3]), .power_cycle_source_in(src[4]), .mode_auto_in, .mode_we_in,
    .control_channel_in, .group_cfg_we_in, .group_attempts_in, .group_timeout_in,
    .fault_detect_in, .inverse_thermal_trip_in, .clear_thermal_cmd_in, .motor_running_in,
    .fault_latched_out, .mode_auto_out, .clear_thermal_capacity_out, .attempt_count_out,
    .attempts_setting_out, .timeout_setting_out);
  mfr_reset_source_model i_mfr_reset_source_model (.mclk_in, .go_in(go), .sel_in(sel),
    .src_out(src));
  initial forever #5 mclk_in = ~mclk_in;
  // ==========================================================================
  // shared tasks; the expected latch vector is the bench's own model
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic flt(input logic [7:0] v);
    fault_detect_in <= v;
    tick(1);
    fault_detect_in <= 8'h00;
    tick(1);
    exp_lat |= v;
    chk(fault_latched_out, exp_lat);
  endtask
  // local sources keep internal faults, a power cycle keeps protection ones
  task automatic src_pulse(input logic [2:0] s);
    go <= 1'b1;
    sel <= s;
    tick(1);
    go <= 1'b0;
    tick(10);
    if (s < 3'h3) exp_lat &= 8'h04;
    if (s == 3'h4) exp_lat &= 8'hF8;
    if (s == 3'h3 && mode_auto_in && control_channel_in == 2'h2) exp_lat &= 8'h06;
    chk(fault_latched_out, exp_lat);
  endtask
  task automatic cfg(input int g, input logic [2:0] a, input logic [15:0] t);
    group_cfg_we_in <= 3'h1 << g;
    group_attempts_in <= a;
    group_timeout_in <= t;
    tick(1);
    group_cfg_we_in <= 3'h0;
    tick(1);
  endtask
  task automatic md(input logic m);
    mode_auto_in <= m;
    mode_we_in <= 1'b1;
    tick(1);
    mode_we_in <= 1'b0;
    tick(1);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard, well above the roughly 1000 cycles of the sequence
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      stop_test;
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'hA66A246D));
    tick(5);
    rst_n_in <= 1'b1;
    tick(2);
    chk({attempts_setting_out, |timeout_setting_out}, 20'h0);
    flt(8'hFF);
    control_channel_in <= 2'h2;
    src_pulse(3'h3);
    for (int s = 0; s < 3; s++) begin
      flt(8'($urandom()) | 8'h04);
      src_pulse(3'(s));
    end
    src_pulse(3'h4);
    flt(8'hFB);
    src_pulse(3'h4);
    src_pulse(3'h1);
    inverse_thermal_trip_in <= 1'b1;
    flt(8'h10);
    clear_thermal_cmd_in <= 1'b1;
    tick(1);
    clear_thermal_cmd_in <= 1'b0;
    hits = 0;
    // the pulse stands from this edge on, so look before waiting
    repeat (4) begin
      #1 hits += int'(clear_thermal_capacity_out);
      @(posedge mclk_in);
    end
    chk(20'(hits), 20'h1);
    src_pulse(3'h0);
    cfg(0, 3'h1, 16'h0002);
    md(1'b1);
    flt(8'h08);
    tick(10);
    chk(fault_latched_out[3], 1'b1);
    tick(25);
    exp_lat = 8'h00;
    chk({fault_latched_out[3], attempt_count_out[2:0]}, 20'h1);
    flt(8'h08);
    tick(35);
    chk({mode_auto_out, fault_latched_out[3]}, 20'h1);
    motor_running_in <= 1'b1;
    tick(4);
    chk({attempts_setting_out[2:0], timeout_setting_out[15:0]}, 20'h0);
    src_pulse(3'h1);
    cfg(0, 3'h5, 16'h0001);
    md(1'b1);
    repeat (3) begin
      flt(8'h08);
      tick(25);
      exp_lat = 8'h00;
      chk({mode_auto_out, fault_latched_out[3]}, 20'h2);
    end
    // one failed attempt carried over from the fall-back run
    chk(attempt_count_out[2:0], 3'h4);
    tick(620);
    chk(attempt_count_out[2:0], 3'h0);
    cfg(1, 3'h0, 16'h0005);
    cfg(2, 3'h7, 16'h0000);
    chk(attempts_setting_out[8:3], 6'h28);
    flt(8'hA0);
    tick(80);
    chk(fault_latched_out, 8'hA0);
    src_pulse(3'h4);
    chk({attempts_setting_out, |timeout_setting_out}, 20'h0);
    // network in automatic mode on the network channel: wiring and internal stay
    flt(8'h07);
    src_pulse(3'h3);
    stop_test;
  end
endmodule // mfr_fault_reset_manager_tb_top
bind mfr_fault_reset_manager mfr_fault_reset_manager_asserts #(.CYCLES_PER_S(CYCLES_PER_S))
  i_mfr_fault_reset_manager_asserts (.mclk_in, .rst_n_in, .reset_input_in, .reset_button_source_in,
  .operator_panel_reset_in, .power_cycle_source_in, .clear_thermal_cmd_in, .motor_running_in,
  .fault_detect_in, .fault_latched_out, .mode_auto_out, .clear_thermal_capacity_out,
  .attempt_count_out, .attempts_setting_out, .timeout_setting_out);
